// ==== common/adc_serial_defs.vh ====
// shared constants for the converter serial port and its result buffer
// assumes inclusion by bare name from files under logic/
`ifndef ADC_SERIAL_DEFS_VH
`define ADC_SERIAL_DEFS_VH

// word layout of a data read and a control write
`define READ_BITS 24
`define READ_MSB 23
`define WRITE_BITS 8
`define WRITE_MSB 7
`define BIT_CNT_W 5
`define READ_LAST 5'h17
`define WRITE_LAST 5'h07
`define BIT_CNT_ZERO 5'h00
`define BIT_CNT_ONE 5'h01

// position of the sampled auxiliary inputs inside the read word
`define AUX_HIGH_POS 4
`define AUX_LOW_POS 3

// least data-ready high time in master-clock periods, before division by n
`define DRDY_HIGH_BASE 10'h118
`define DRDY_HIGH_X2 10'h230
`define DRDY_CNT_W 10
`define DRDY_CNT_ZERO 10'h000
`define DRDY_CNT_ONE 10'h001

// result buffer depth
`define BUF_DEPTH 2
`define BUF_CNT_W 2
`define BUF_IDX_W 1
`define BUF_FULL 2'h2
`define BUF_CNT_ONE 2'h1

`endif

// ==== logic/adc_serial_port.v ====
// serial host port of a sigma-delta converter: data-ready, reads, writes
// assumes pins are asynchronous to ref_clk and sclk pulses last >= 100 ns
`timescale 1ns/1ps
`include "adc_serial_defs.vh"

module adc_serial_port
(
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // serial pins
  input wire sclk,
  input wire cs_n,
  input wire din,
  output wire dout,
  output wire dout_oe,
  output wire data_ready_n,
  // auxiliary pins and master clock pin
  input wire aux_input_0,
  input wire aux_input_1,
  input wire master_clock_in,
  // configuration from the control logic
  input wire clock_doubler_sel,
  input wire modulator_rate_hi,
  input wire modulator_rate_lo,
  input wire read_mode,
  // conversion results from the filter
  input wire [`READ_MSB:0] result_data,
  input wire result_valid,
  output wire result_ready,
  // control words written by the host
  output wire [`WRITE_MSB:0] cmd_data,
  output wire cmd_valid,
  // nominal-rate master clock enable for the modulator
  output wire modulator_tick
);

  localparam ST_HIGH = 2'b01;
  localparam ST_LOW = 2'b10;

  // least high time: base shifted down by 2*hi+lo
  function [`DRDY_CNT_W-1:0] drdy_min;
    input x2;
    input hi;
    input lo;
    reg [`DRDY_CNT_W-1:0] base;
    begin
      base = x2 ? `DRDY_HIGH_X2 : `DRDY_HIGH_BASE;
      drdy_min = base >> {hi, lo};
    end
  endfunction

  // read word with the sampled aux inputs inserted
  function [`READ_MSB:0] read_word;
    input [`READ_MSB:0] word;
    input a1;
    input a0;
    reg [`READ_MSB:0] w;
    begin
      w = word;
      w[`AUX_HIGH_POS] = a1;
      w[`AUX_LOW_POS] = a0;
      read_word = w;
    end
  endfunction

  // two-flop synchronisers for every pin, plus a third stage for edges
  reg [1:0] sclk_sync_ff, cs_sync_ff, din_sync_ff, mclk_sync_ff;
  reg [1:0] aux0_sync_ff, aux1_sync_ff;
  reg sclk_prev_ff, cs_prev_ff, mclk_prev_ff;
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_sync_ff <= 2'h3;
      cs_sync_ff <= 2'h3;
      din_sync_ff <= 2'h0;
      mclk_sync_ff <= 2'h0;
      aux0_sync_ff <= 2'h0;
      aux1_sync_ff <= 2'h0;
      sclk_prev_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
      mclk_prev_ff <= 1'b0;
    end
    else
    begin
      sclk_sync_ff <= {sclk_sync_ff[0], sclk};
      cs_sync_ff <= {cs_sync_ff[0], cs_n};
      din_sync_ff <= {din_sync_ff[0], din};
      mclk_sync_ff <= {mclk_sync_ff[0], master_clock_in};
      aux0_sync_ff <= {aux0_sync_ff[0], aux_input_0};
      aux1_sync_ff <= {aux1_sync_ff[0], aux_input_1};
      sclk_prev_ff <= sclk_sync_ff[1];
      cs_prev_ff <= cs_sync_ff[1];
      mclk_prev_ff <= mclk_sync_ff[1];
    end
  end

  wire sclk_s = sclk_sync_ff[1];
  wire cs_s = cs_sync_ff[1];
  wire sclk_rise = sclk_s & ~sclk_prev_ff;
  wire sclk_fall = ~sclk_s & sclk_prev_ff;
  wire cs_fall = ~cs_s & cs_prev_ff;
  wire mclk_rise = mclk_sync_ff[1] & ~mclk_prev_ff;

  // run only once the master clock is seen toggling after reset
  reg run_ff;
  reg half_ff;
  reg tick_ff;
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run_ff <= 1'b0;
      half_ff <= 1'b0;
      tick_ff <= 1'b0;
    end
    else
    begin
      if (mclk_rise)
        run_ff <= 1'b1;
      if (mclk_rise)
        half_ff <= clock_doubler_sel ? ~half_ff : 1'b0;
      // doubled clock yields a tick on every other edge
      tick_ff <= mclk_rise & (~clock_doubler_sel | half_ff);
    end
  end
  assign modulator_tick = tick_ff;

  // sclk idle level caught when chip select falls; tied low catches the sclk level just after reset
  reg idle_high_ff;
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      idle_high_ff <= 1'b1;
    else if (cs_fall)
      idle_high_ff <= sclk_s;
  end

  wire frame_on = ~cs_s & run_ff;
  wire shift_edge = frame_on & (idle_high_ff ? sclk_fall : sclk_rise);
  wire capture_edge = frame_on & (idle_high_ff ? sclk_rise : sclk_fall);

  // frame engine state
  reg started_ff, is_read_ff, dout_ff, cmd_valid_ff;
  reg [`BIT_CNT_W-1:0] bit_cnt_ff;
  reg [`READ_MSB:0] shift_ff;
  reg [`READ_MSB:0] out_word_ff;
  reg [`WRITE_MSB:0] wr_shift_ff;
  reg [`WRITE_MSB:0] cmd_data_ff;
  wire read_done = capture_edge & started_ff & is_read_ff & (bit_cnt_ff == `READ_LAST);
  wire write_done = capture_edge & started_ff & ~is_read_ff & (bit_cnt_ff == `WRITE_LAST);
  wire [`READ_MSB:0] first_word = read_word(out_word_ff, aux1_sync_ff[1], aux0_sync_ff[1]);

  // shift, capture and count; chip select high or a full word ends the frame
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      started_ff <= 1'b0;
      is_read_ff <= 1'b0;
      dout_ff <= 1'b0;
      cmd_valid_ff <= 1'b0;
      bit_cnt_ff <= `BIT_CNT_ZERO;
      shift_ff <= {`READ_BITS{1'b0}};
      wr_shift_ff <= {`WRITE_BITS{1'b0}};
      cmd_data_ff <= {`WRITE_BITS{1'b0}};
    end
    else
    begin
      cmd_valid_ff <= 1'b0;
      if (!frame_on)
      begin
        started_ff <= 1'b0;
        bit_cnt_ff <= `BIT_CNT_ZERO;
      end
      else if (read_done || write_done)
      begin
        // word complete; next shift edge opens a fresh frame
        started_ff <= 1'b0;
        bit_cnt_ff <= `BIT_CNT_ZERO;
        if (write_done)
        begin
          cmd_data_ff <= {wr_shift_ff[`WRITE_MSB-1:0], din_sync_ff[1]};
          cmd_valid_ff <= 1'b1;
        end
      end
      else if (shift_edge && !started_ff)
      begin
        started_ff <= 1'b1;
        is_read_ff <= read_mode;
        // aux pins sampled here and frozen into the word
        shift_ff <= {first_word[`READ_MSB-1:0], 1'b0};
        dout_ff <= first_word[`READ_MSB];
      end
      else if (shift_edge && is_read_ff)
      begin
        dout_ff <= shift_ff[`READ_MSB];
        shift_ff <= {shift_ff[`READ_MSB-1:0], 1'b0};
      end
      else if (capture_edge && started_ff)
      begin
        bit_cnt_ff <= bit_cnt_ff + `BIT_CNT_ONE;
        if (!is_read_ff)
          wr_shift_ff <= {wr_shift_ff[`WRITE_MSB-1:0], din_sync_ff[1]};
      end
    end
  end

  assign dout = dout_ff;
  assign dout_oe = frame_on & started_ff & is_read_ff;
  assign cmd_data = cmd_data_ff;
  assign cmd_valid = cmd_valid_ff;

  // result buffer absorbs filter words while the host is slow
  wire [`READ_MSB:0] buf_data;
  wire buf_valid;
  reg [1:0] state_ff;
  reg [`DRDY_CNT_W-1:0] high_cnt_ff;
  wire high_met = (high_cnt_ff >= drdy_min(clock_doubler_sel, modulator_rate_hi,
                                           modulator_rate_lo));
  // no update during a read or as one opens, so a read never clears a fresh word
  wire load = (state_ff == ST_HIGH) & high_met & buf_valid & run_ff &
              ~(started_ff & is_read_ff) & ~(shift_edge & ~started_ff & read_mode);

  result_buffer u_buf
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_data(result_data),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(load)
  );

  // data-ready state: high while waiting out the least time, low until read
  reg [1:0] nxt_state;
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_HIGH:
        if (load)
          nxt_state = ST_LOW;
      ST_LOW:
        if (read_done)
          nxt_state = ST_HIGH;
      default:
        nxt_state = ST_HIGH;
    endcase
  end

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= ST_HIGH;
      high_cnt_ff <= `DRDY_CNT_ZERO;
      out_word_ff <= {`READ_BITS{1'b0}};
    end
    else
    begin
      state_ff <= nxt_state;
      if (load)
        out_word_ff <= buf_data;
      // count raw master periods from the rise of data-ready
      if (state_ff != ST_HIGH)
        high_cnt_ff <= `DRDY_CNT_ZERO;
      else if (mclk_rise && !high_met)
        high_cnt_ff <= high_cnt_ff + `DRDY_CNT_ONE;
    end
  end

  assign data_ready_n = (state_ff != ST_LOW);

endmodule

// ==== logic/result_buffer.v ====
// two-entry valid/ready buffer between the filter and the output word
// assumes both sides run on ref_clk; storage is flip-flops indexed by pointer
`timescale 1ns/1ps
`include "adc_serial_defs.vh"

module result_buffer
(
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // filling side
  input wire [`READ_MSB:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // draining side
  output wire [`READ_MSB:0] out_data,
  output wire out_valid,
  input wire out_ready
);

  reg [`READ_MSB:0] mem_ff [0:`BUF_DEPTH-1];
  reg [`BUF_IDX_W-1:0] wr_ptr_ff;
  reg [`BUF_IDX_W-1:0] rd_ptr_ff;
  reg [`BUF_CNT_W-1:0] count_ff;
  wire push;
  wire pop;

  // honest full and empty from the fill count
  assign in_ready = (count_ff != `BUF_FULL);
  assign out_valid = (count_ff != {`BUF_CNT_W{1'b0}});
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointers wrap naturally with a one-bit index
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_ff <= {`BUF_IDX_W{1'b0}};
      rd_ptr_ff <= {`BUF_IDX_W{1'b0}};
      count_ff <= {`BUF_CNT_W{1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push && !pop)
        count_ff <= count_ff + `BUF_CNT_ONE;
      else if (pop && !push)
        count_ff <= count_ff - `BUF_CNT_ONE;
    end
  end

  // data storage needs no reset; valid gating covers stale words
  always @(posedge ref_clk)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end

endmodule

// ==== testbench/adc_serial_port_sva.sv ====
// checker for the converter serial port, on its top-level ports only
// assumes the host keeps each sclk phase >= 20 ref_clk cycles
`timescale 1ns/1ps
`include "adc_serial_defs.vh"
module adc_serial_port_sva
(
  // clock and reset
  input wire ref_clk,
  input wire reset_n,
  // serial pins
  input wire sclk,
  input wire cs_n,
  input wire dout,
  input wire dout_oe,
  input wire data_ready_n,
  // master clock and setup
  input wire master_clock_in,
  input wire clock_doubler_sel,
  input wire modulator_rate_hi,
  input wire modulator_rate_lo,
  // control word strobe
  input wire cmd_valid
);
  reg mclk_ff;
  reg [9:0] rise_cnt_ff;
  wire [9:0] base = clock_doubler_sel ? `DRDY_HIGH_X2 : `DRDY_HIGH_BASE;
  wire [9:0] need = base >> {modulator_rate_hi, modulator_rate_lo};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // master rises while data-ready is high; 3ff exempts the first update
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mclk_ff <= 1'b0;
      rise_cnt_ff <= 10'h3ff;
    end
    else
    begin
      mclk_ff <= master_clock_in;
      if (!data_ready_n)
        rise_cnt_ff <= 10'h000;
      else if (master_clock_in && !mclk_ff && rise_cnt_ff != 10'h3ff)
        rise_cnt_ff <= rise_cnt_ff + 10'h001;
    end
  end
  high_time_a: assert property (
    $fell(data_ready_n) |-> rise_cnt_ff == 10'h3ff || rise_cnt_ff + 10'h001 >= need)
    else $error("short high time");
  ready_read_a: assert property (
    $rose(data_ready_n) |-> $past(dout_oe, 1) || $past(dout_oe, 2) || $past(dout_oe, 3))
    else $error("data ready rose without read");
  update_idle_a: assert property (
    $fell(data_ready_n) |-> !dout_oe) else $error("update during read");
  shift_edge_a: assert property (
    dout_oe && $changed(dout) |-> $past(sclk, 2) != $past(sclk, 6))
    else $error("dout moved off shift edge");
  desel_quiet_a: assert property (
    cs_n [*5] |-> !dout_oe) else $error("dout driven while deselected");
  sel_drive_a: assert property (
    $rose(dout_oe) |-> !$past(cs_n, 3) && !$past(cs_n, 4)) else $error("drive without select");
  cmd_pulse_a: assert property (
    cmd_valid |=> !cmd_valid) else $error("command strobe too long");
  cmd_frame_a: assert property (
    cmd_valid |-> !dout_oe && !$past(cs_n, 4)) else $error("command outside write frame");
endmodule
bind adc_serial_port adc_serial_port_sva i_adc_serial_port_sva (.ref_clk, .reset_n, .sclk,
  .cs_n, .dout, .dout_oe, .data_ready_n, .master_clock_in, .clock_doubler_sel,
  .modulator_rate_hi, .modulator_rate_lo, .cmd_valid);

// ==== testbench/spi_host_model.sv ====
// behavioural host on the serial link: frames, shifts and captures bits
// assumes ref_clk at 5 ns; each sclk phase is 20 cycles (100 ns)
`timescale 1ns/1ps
module spi_host_model
(
  // clock
  input wire ref_clk,
  // serial pins
  output reg sclk,
  output reg cs_n,
  output reg din,
  input wire dout
);
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // one sclk phase, long enough for the pin synchronisers
  task phase;
    repeat (20) @(posedge ref_clk);
  endtask
  // one framed access of n bits msb first; chip select toggled every time
  task xfer(input idle, input [23:0] tx, input integer n, output [23:0] rx);
    integer i;
    begin
      rx = 24'h000000;
      sclk <= idle;
      phase;
      cs_n <= 1'b0;
      phase;
      for (i = n - 1; i >= 0; i = i - 1)
      begin
        sclk <= ~idle; // shift edge
        din <= tx[i];
        phase;
        sclk <= idle;
        rx[i] = dout; // capture edge
        phase;
      end
      cs_n <= 1'b1;
      din <= ~din; // released line shows no stale bit
      phase;
    end
  endtask
endmodule

// ==== testbench/test_adc_serial_port.sv ====
// bench for the converter serial port: updates, reads, rereads, writes
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ps
`include "adc_serial_defs.vh"
module test_adc_serial_port;
  reg ref_clk = 1'b0;
  reg reset_n = 1'b0;
  reg master_clock_in = 1'b0;
  reg mclk_on = 1'b0;
  reg doubler = 1'b1;
  integer tick_cnt = 0;
  wire tick;
  reg [2:0] mdiv = 3'h0;
  reg [1:0] aux = 2'h0;
  reg read_mode = 1'b1;
  reg [23:0] result_data = 24'h000000;
  reg result_valid = 1'b0;
  reg [7:0] cmd_seen = 8'h00;
  reg [23:0] rx;
  integer errors = 0;
  integer num_checks = 0;
  integer cycles = 0;
  integer k;
  wire sclk, cs_n, din, dout, dout_oe, data_ready_n, result_ready, cmd_valid;
  wire [`WRITE_MSB:0] cmd_data;
  adc_serial_port i_adc_serial_port (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe), .data_ready_n(data_ready_n),
    .aux_input_0(aux[0]), .aux_input_1(aux[1]), .master_clock_in(master_clock_in),
    .clock_doubler_sel(doubler), .modulator_rate_hi(1'b1), .modulator_rate_lo(1'b1),
    .read_mode(read_mode), .result_data(result_data), .result_valid(result_valid),
    .result_ready(result_ready), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
    .modulator_tick(tick));
  spi_host_model i_spi_host_model (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout));
  initial
    forever #2.5 ref_clk = ~ref_clk;
  // master clock of 8 cycles once enabled, command capture and the hang limit
  always @(posedge ref_clk)
  begin
    if (mclk_on)
    begin
      mdiv <= mdiv + 3'h1;
      master_clock_in <= mdiv[2];
    end
    if (cmd_valid === 1'b1)
      cmd_seen <= cmd_data;
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      errors = errors + 1;
      results;
    end
  end
  task chk(input [23:0] seen, input [23:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      if (errors == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // valid held until ready is seen at a rising edge; called at a rising edge
  task push(input [23:0] w);
    begin
      result_data <= w;
      result_valid <= 1'b1;
      @(negedge ref_clk);
      while (result_ready !== 1'b1)
        @(negedge ref_clk);
      @(posedge ref_clk);
    end
  endtask
  task wait_low;
    begin
      while (data_ready_n !== 1'b0)
        @(posedge ref_clk);
      @(posedge ref_clk);
    end
  endtask
  task read(input idle, input [1:0] a, input [23:0] w);
    begin
      aux <= a;
      read_mode <= 1'b1;
      i_spi_host_model.xfer(idle, 24'h000000, 24, rx);
      chk(rx, {w[23:5], a, w[2:0]});
    end
  endtask
  // three updates fill output word and buffer; a fourth is held off
  task t_updates;
    begin
      push(24'h123456);
      result_valid <= 1'b0;
      wait_low;
      push(24'habcdef);
      push(24'h5a5a5a);
      result_data <= 24'hdead00;
      repeat (10) @(posedge ref_clk);
      chk(result_ready, 24'h0);
      result_valid <= 1'b0;
      read(1'b1, 2'b10, 24'h123456);
      chk(data_ready_n, 24'h1);
      wait_low;
      read(1'b1, 2'b01, 24'habcdef);
      chk(data_ready_n, 24'h1);
      read(1'b1, 2'b10, 24'habcdef);
      // pending update held off during the reread, then loaded at once
      chk(data_ready_n, 24'h0);
      wait_low;
      read(1'b0, 2'b11, 24'h5a5a5a);
    end
  endtask
  // frame ignored until the master clock toggles after reset
  task t_stopped;
    begin
      read_mode <= 1'b0;
      i_spi_host_model.xfer(1'b1, 24'h00005a, 8, rx);
      chk(cmd_seen, 24'h000000);
      chk(data_ready_n, 24'h1);
      mclk_on <= 1'b1;
      repeat (10) @(posedge ref_clk);
    end
  endtask
  // modulator enable rate over 20 master periods, doubler on or off
  task t_ticks(input x2, input [23:0] exp);
    begin
      @(posedge ref_clk);
      doubler <= x2;
      repeat (40) @(posedge ref_clk);
      tick_cnt = 0;
      repeat (160)
      begin
        @(negedge ref_clk);
        if (tick === 1'b1)
          tick_cnt = tick_cnt + 1;
      end
      chk(tick_cnt, exp);
    end
  endtask
  // control writes in both idle levels
  task t_writes;
    begin
      for (k = 0; k < 2; k = k + 1)
      begin
        read_mode <= 1'b0;
        i_spi_host_model.xfer(k == 0, 24'h0000a5 ^ k, 8, rx);
        chk(cmd_seen, 24'h0000a5 ^ k);
      end
    end
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    t_stopped;
    t_updates;
    t_writes;
    t_ticks(1'b1, 24'h00000a);
    t_ticks(1'b0, 24'h000014);
    results;
  end
endmodule
